/* File: wtt_pkg.sv */
// Purpose: Shared constants for the write turnaround timing block.
// Assumes: Register words are 32 bits wide at byte offsets.
// Notes: Command codes and register offsets are local choices.

// ****************************************
// Package
// ****************************************
package wtt_pkg;
  localparam int unsigned CLOCK_MHZ = 125;
  localparam int unsigned LINK_PERIOD_NS = 64;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned PIN_COUNT = 19;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_LATENCY = 8'h04;
  localparam logic [7:0] OFF_RECOVERY = 8'h08;
  localparam logic [7:0] OFF_WTR = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int unsigned MODE_BURST_LSB = 0;
  localparam int unsigned MODE_DBI_BIT = 2;
  localparam int unsigned AL_LSB = 0;
  localparam int unsigned CWL_LSB = 8;
  localparam int unsigned WR_LSB = 0;
  localparam int unsigned WR_DBI_LSB = 8;
  localparam int unsigned WTR_S_LSB = 0;
  localparam int unsigned WTR_L_LSB = 8;
  localparam int unsigned ST_READ_EARLY = 2;
  localparam int unsigned ST_PRE_EARLY = 3;
  localparam int unsigned ST_OVERFLOW = 4;
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;
  localparam logic [2:0] CMD_WRITE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [3:0] BEATS_EIGHT = 4'h8;
  localparam logic [3:0] BEATS_FOUR = 4'h4;
  localparam logic [2:0] RESET_MODE = 3'h0;
  localparam logic [4:0] RESET_AL = 5'h00;
  localparam logic [4:0] RESET_CWL = 5'h09;
  localparam logic [7:0] RESET_WR = 8'h0c;
  localparam logic [7:0] RESET_WR_DBI = 8'h0d;
  localparam logic [7:0] RESET_WTR_S = 8'h02;
  localparam logic [7:0] RESET_WTR_L = 8'h06;
  typedef enum logic [1:0] {WTT_IDLE, WTT_LATENCY, WTT_BURST, WTT_RECOVERY} wtt_state_t;
endpackage : wtt_pkg

/* File: wtt_fifo.sv */
// Purpose: Write data buffer with registered read data.
// Assumes: One clock; push only while in_ready is high.
// Notes: Output stage is a register so out_data and out_valid are flops.

`timescale 1ns/1ps
`default_nettype none

module wtt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire logic push;
  wire logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr <= wptr + 1'b1;
      end
      if (pop)
      begin
        rptr <= rptr + 1'b1;
        out_data <= mem[rptr];
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
      if (pop)
      begin
        out_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule : wtt_fifo

`default_nettype wire

/* File: wtt_write_turnaround.sv */
// Purpose: Device-side write burst, recovery and write-to-read turnaround timing.
// Assumes: Link pins are asynchronous and sampled at the core clock.
// Notes: One write burst is tracked at a time; a new write restarts tracking.
//
// Function
// - Eight beats for mode 00, or 01 with bit high.
// - Mode 01 with bit low gives four-beat chop.
// - Mode 10 always gives four-beat chop.
// - Write latency is additive plus cas write latency.
// - Auto precharge starts after recovery from last beat.
//
// Design decisions made here: the address map and the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none

module wtt_write_turnaround (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic link_clk,
  input wire logic cmd_select_n,
  input wire logic [2:0] cmd_code,
  input wire logic [1:0] bank_group,
  input wire logic [1:0] bank,
  input wire logic burst_chop_select_address_bit,
  input wire logic auto_precharge,
  input wire logic [7:0] dq,
  output logic [7:0] wdata_out,
  output logic wdata_valid,
  input wire logic wdata_ready,
  output logic internal_precharge,
  output logic [3:0] precharge_bank
);
  // ****************************************
  // Pin sampling
  // ****************************************
  logic [wtt_pkg::PIN_COUNT-1:0] s1;
  logic [wtt_pkg::PIN_COUNT-1:0] s2;
  logic [wtt_pkg::PIN_COUNT-1:0] s3;
  logic [wtt_pkg::PIN_COUNT-1:0] pins;
  logic clk_prev;
  wire logic [wtt_pkg::PIN_COUNT-1:0] raw_pins = {link_clk, cmd_select_n, cmd_code, bank_group, bank,
                                                  burst_chop_select_address_bit, auto_precharge, dq};

  // A pin changes only once the second and third stages agree.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pins <= '0;
      clk_prev <= 1'b0;
    end
    else
    begin
      s1 <= raw_pins;
      s2 <= s1;
      s3 <= s2;
      pins <= (s2 & s3) | (pins & (s2 ^ s3));
      clk_prev <= pins[18];
    end
  end

  wire logic rise = pins[18] && !clk_prev;
  wire logic fall = !pins[18] && clk_prev;
  wire logic p_sel = !pins[17];
  wire logic [2:0] p_cmd = pins[16:14];
  wire logic [1:0] p_group = pins[13:12];
  wire logic [1:0] p_bank = pins[11:10];
  wire logic p_chop_bit = pins[9];
  wire logic p_ap = pins[8];
  wire logic [7:0] p_dq = pins[7:0];

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0] mode_reg;
  logic [4:0] al_reg;
  logic [4:0] cwl_reg;
  logic [7:0] wr_reg;
  logic [7:0] wr_dbi_reg;
  logic [7:0] wtr_s_reg;
  logic [7:0] wtr_l_reg;
  logic [2:0] sticky;

  wire logic sel_mode = (reg_addr == wtt_pkg::OFF_MODE);
  wire logic sel_lat = (reg_addr == wtt_pkg::OFF_LATENCY);
  wire logic sel_rec = (reg_addr == wtt_pkg::OFF_RECOVERY);
  wire logic sel_wtr = (reg_addr == wtt_pkg::OFF_WTR);
  wire logic sel_stat = (reg_addr == wtt_pkg::OFF_STATUS);

  wtt_pkg::wtt_state_t state;
  logic burst_four;
  wire logic [31:0] status_word = {26'h0, sticky, burst_four, state};
  wire logic [31:0] read_mux = sel_mode ? {29'h0, mode_reg} :
                               sel_lat ? {19'h0, cwl_reg, 3'h0, al_reg} :
                               sel_rec ? {16'h0, wr_dbi_reg, wr_reg} :
                               sel_wtr ? {16'h0, wtr_l_reg, wtr_s_reg} :
                               sel_stat ? status_word : 32'h0;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_reg <= wtt_pkg::RESET_MODE;
      al_reg <= wtt_pkg::RESET_AL;
      cwl_reg <= wtt_pkg::RESET_CWL;
      wr_reg <= wtt_pkg::RESET_WR;
      wr_dbi_reg <= wtt_pkg::RESET_WR_DBI;
      wtr_s_reg <= wtt_pkg::RESET_WTR_S;
      wtr_l_reg <= wtt_pkg::RESET_WTR_L;
      reg_rdata <= 32'h0;
    end
    else
    begin
      reg_rdata <= reg_read ? read_mux : 32'h0;
      if (reg_write && sel_mode)
      begin
        mode_reg <= reg_wdata[2:0];
      end
      if (reg_write && sel_lat)
      begin
        al_reg <= reg_wdata[wtt_pkg::AL_LSB +: 5];
        cwl_reg <= reg_wdata[wtt_pkg::CWL_LSB +: 5];
      end
      if (reg_write && sel_rec)
      begin
        wr_reg <= reg_wdata[wtt_pkg::WR_LSB +: 8];
        wr_dbi_reg <= reg_wdata[wtt_pkg::WR_DBI_LSB +: 8];
      end
      if (reg_write && sel_wtr)
      begin
        wtr_s_reg <= reg_wdata[wtt_pkg::WTR_S_LSB +: 8];
        wtr_l_reg <= reg_wdata[wtt_pkg::WTR_L_LSB +: 8];
      end
    end
  end

  // ****************************************
  // Burst length and latency
  // ****************************************
  wire logic [1:0] burst_mode = mode_reg[wtt_pkg::MODE_BURST_LSB +: 2];
  wire logic dbi_on = mode_reg[wtt_pkg::MODE_DBI_BIT];
  wire logic cmd_chop = (burst_mode == wtt_pkg::BURST_FIXED4) ||
                        (burst_mode == wtt_pkg::BURST_OTF && !p_chop_bit);
  wire logic [5:0] write_latency = 6'(al_reg) + 6'(cwl_reg);
  wire logic [7:0] recovery = dbi_on ? wr_dbi_reg : wr_reg;
  wire logic cmd_taken = rise && p_sel;

  // ****************************************
  // Burst tracking
  // ****************************************
  logic [5:0] lat_cnt;
  logic [3:0] beat_cnt;
  logic [7:0] rec_cnt;
  logic [7:0] since;
  logic track;
  logic first_rise;
  logic wr_ap;
  logic [1:0] wr_group;
  logic [1:0] wr_bank;
  wire logic [3:0] beats = burst_four ? wtt_pkg::BEATS_FOUR : wtt_pkg::BEATS_EIGHT;
  wire logic beat_now = (state == wtt_pkg::WTT_BURST) && (rise || fall);
  wire logic fifo_ready;
  wire logic data_start = rise && state == wtt_pkg::WTT_LATENCY && lat_cnt == 6'h01;
  wire logic push = beat_now || data_start;
  wire logic last_beat = beat_now && beat_cnt == beats - 4'h1;
  wire logic [7:0] wtr_need = (p_group == wr_group) ? wtr_l_reg : wtr_s_reg;
  wire logic read_early = cmd_taken && p_cmd == wtt_pkg::CMD_READ && track && since < wtr_need;
  wire logic pre_early = cmd_taken && p_cmd == wtt_pkg::CMD_PRECHARGE && track &&
                         p_group == wr_group && p_bank == wr_bank && since < recovery;
  wire logic new_write = cmd_taken && p_cmd == wtt_pkg::CMD_WRITE;
  wire logic [2:0] sticky_set = {push && !fifo_ready, pre_early, read_early};
  wire logic [2:0] sticky_clr = (reg_write && sel_stat) ? reg_wdata[wtt_pkg::ST_OVERFLOW:wtt_pkg::ST_READ_EARLY] : 3'h0;
  wire logic fire = rise && state == wtt_pkg::WTT_RECOVERY && !first_rise && rec_cnt <= 8'h01;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= wtt_pkg::WTT_IDLE;
      lat_cnt <= 6'h00;
      beat_cnt <= 4'h0;
      rec_cnt <= 8'h00;
      since <= 8'h00;
      track <= 1'b0;
      first_rise <= 1'b0;
      burst_four <= 1'b0;
      wr_ap <= 1'b0;
      wr_group <= 2'h0;
      wr_bank <= 2'h0;
      sticky <= 3'h0;
      internal_precharge <= 1'b0;
      precharge_bank <= 4'h0;
    end
    else
    begin
      // Set wins over a software clear in the same cycle.
      sticky <= (sticky & ~sticky_clr) | sticky_set;
      internal_precharge <= fire && wr_ap;
      if (fire)
      begin
        precharge_bank <= {wr_group, wr_bank};
      end
      if (rise && track && since != 8'hff)
      begin
        since <= since + 8'h01;
      end
      if (new_write)
      begin
        state <= wtt_pkg::WTT_LATENCY;
        lat_cnt <= write_latency;
        burst_four <= cmd_chop;
        wr_ap <= p_ap;
        wr_group <= p_group;
        wr_bank <= p_bank;
        track <= 1'b0;
      end
      else
      begin
        case (state)
          wtt_pkg::WTT_LATENCY:
          begin
            if (data_start)
            begin
              state <= wtt_pkg::WTT_BURST;
              beat_cnt <= 4'h1;
            end
            else if (rise)
            begin
              lat_cnt <= lat_cnt - 6'h01;
            end
          end
          wtt_pkg::WTT_BURST:
          begin
            if (last_beat)
            begin
              state <= wtt_pkg::WTT_RECOVERY;
              first_rise <= 1'b1;
            end
            else if (beat_now)
            begin
              beat_cnt <= beat_cnt + 4'h1;
            end
          end
          wtt_pkg::WTT_RECOVERY:
          begin
            // Recovery and turnaround are counted from the first rise after the last beat.
            if (rise && first_rise)
            begin
              first_rise <= 1'b0;
              rec_cnt <= recovery;
              since <= 8'h00;
              track <= 1'b1;
            end
            else if (fire)
            begin
              state <= wtt_pkg::WTT_IDLE;
            end
            else if (rise)
            begin
              rec_cnt <= rec_cnt - 8'h01;
            end
          end
          default:
          begin
            state <= wtt_pkg::WTT_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Write data buffer
  // ****************************************
  wtt_fifo #(
    .WIDTH(wtt_pkg::FIFO_WIDTH),
    .DEPTH(wtt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(p_dq),
    .out_valid(wdata_valid),
    .out_ready(wdata_ready),
    .out_data(wdata_out)
  );
endmodule : wtt_write_turnaround

`default_nettype wire

/* File: wtt_write_turnaround_asserts.sv */
// Purpose: Port checker for the write turnaround block.
// Assumes: Link pins are asynchronous to clock.
// Notes: Attached by bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module wtt_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic cmd_select_n,
  input wire logic [2:0] cmd_code,
  input wire logic [7:0] wdata_out,
  input wire logic wdata_valid,
  input wire logic wdata_ready,
  input wire logic internal_precharge,
  input wire logic [3:0] precharge_bank
);
  logic [7:0] since;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Counts core cycles since a write command was last on the pins.
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      since <= 8'h00;
    else if (!cmd_select_n && cmd_code == wtt_pkg::CMD_WRITE)
      since <= 8'h00;
    else if (since != 8'hff)
      since <= since + 8'h01;
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_beat_hold: assert property (wdata_valid && !wdata_ready |=> wdata_valid && $stable(wdata_out))
    else $error("beat dropped or changed while stalled");
  a_pulse_single: assert property (internal_precharge |=> !internal_precharge)
    else $error("precharge pulse longer than one cycle");
  a_pulse_late: assert property (internal_precharge |-> since > 8'h10)
    else $error("precharge started too soon after write");
  a_bank_stable: assert property (internal_precharge |=> $stable(precharge_bank) [*3])
    else $error("precharge bank moved after pulse");
  c_pulse: cover property (internal_precharge);
  c_stall: cover property (wdata_valid && !wdata_ready);
  c_read: cover property (reg_read ##1 reg_rdata != 32'h0);
endmodule : wtt_chk
bind wtt_write_turnaround wtt_chk chk_i (.clock, .rstn, .reg_read, .reg_rdata, .cmd_select_n, .cmd_code,
  .wdata_out, .wdata_valid, .wdata_ready, .internal_precharge, .precharge_bank);
`default_nettype wire

/* File: wtt_ctrl_model.sv */
// Purpose: Memory controller model on the link pins.
// Assumes: Link clock runs only inside transfers, 64 ns period.
// Notes: Released pins show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module wtt_ctrl_model (
  output logic link_clk,
  output logic cmd_select_n,
  output logic [2:0] cmd_code,
  output logic [1:0] bank_group,
  output logic [1:0] bank,
  output logic burst_chop_select_address_bit,
  output logic auto_precharge,
  output logic [7:0] dq
);
  logic [8:0] cbus;
  assign {cmd_code, bank_group, bank, burst_chop_select_address_bit, auto_precharge} = cbus;
  initial
  begin
    link_clk = 1'b0;
    cmd_select_n = 1'b1;
    cbus = 9'h000;
    dq = 8'h00;
  end
  task automatic slot();
    #16 link_clk = 1'b1;
    #32 link_clk = 1'b0;
    #16;
  endtask : slot
  task automatic send(input logic [2:0] c, input logic [1:0] g, input logic [1:0] b, input logic a,
    input logic p);
    cmd_select_n = 1'b0;
    cbus = {c, g, b, a, p};
    slot();
    cmd_select_n = 1'b1;
    cbus = ~cbus;
  endtask : send
  task automatic write_burst(input logic [1:0] g, input logic [1:0] b, input logic a, input logic p,
    input int wl, input int beats, input int tail, input logic [7:0] d0);
    send(wtt_pkg::CMD_WRITE, g, b, a, p);
    repeat (wl - 1) slot();
    for (int i = 0; i < beats; i += 2)
    begin
      dq = d0 + 8'(i);
      #16 link_clk = 1'b1;
      #16 dq = d0 + 8'(i + 1);
      #16 link_clk = 1'b0;
      #16;
    end
    dq = ~dq;
    repeat (tail) slot();
  endtask : write_burst
endmodule : wtt_ctrl_model
`default_nettype wire

/* File: test_wtt_write_turnaround.sv */
// Purpose: Self-checking bench for the write turnaround block.
// Assumes: Latency 3 and short recovery are programmed first.
// Notes: Buffer depth is 32 plus the output register.
`timescale 1ns/1ps
`default_nettype none
module test_wtt_write_turnaround;
  logic clock, rstn, reg_write, reg_read, wdata_ready, wdata_valid, internal_precharge;
  logic link_clk, cmd_select_n, burst_chop_select_address_bit, auto_precharge;
  logic [7:0] reg_addr, dq, wdata_out;
  logic [31:0] reg_wdata, reg_rdata, d, n_rise, n_pulse, pulse_rise;
  logic [2:0] cmd_code;
  logic [1:0] bank_group, bank;
  logic [3:0] precharge_bank, pulse_bank;
  logic [7:0] cap [$];
  logic [31:0] mode_t [4] = '{32'h0, 32'h1, 32'h1, 32'h2};
  logic a12_t [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [31:0] nb_t [4] = '{32'd8, 32'd8, 32'd4, 32'd4};
  int n_errors = 0;
  int n_compared = 0;
  wtt_write_turnaround uut (.clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .link_clk, .cmd_select_n, .cmd_code, .bank_group, .bank, .burst_chop_select_address_bit,
    .auto_precharge, .dq, .wdata_out, .wdata_valid, .wdata_ready, .internal_precharge, .precharge_bank);
  wtt_ctrl_model ctl (.link_clk, .cmd_select_n, .cmd_code, .bank_group, .bank,
    .burst_chop_select_address_bit, .auto_precharge, .dq);
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge link_clk) n_rise++;
  always @(posedge clock)
  begin
    if (wdata_valid === 1'b1 && wdata_ready === 1'b1) cap.push_back(wdata_out);
    if (internal_precharge === 1'b1)
    begin
      n_pulse++;
      pulse_rise = n_rise;
      pulse_bank = precharge_bank;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask : rd
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    #300000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    rstn = 1'b0;
    {reg_addr, reg_wdata, reg_write, reg_read, n_rise, n_pulse} = '0;
    wdata_ready = 1'b1;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    rd(wtt_pkg::OFF_LATENCY, d);
    chk("latency", d, 32'h0900);
    rd(wtt_pkg::OFF_RECOVERY, d);
    chk("recovery", d, 32'h0d0c);
    rd(wtt_pkg::OFF_WTR, d);
    chk("wtr", d, 32'h0602);
    wr(8'h20, 32'hffff);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    wr(wtt_pkg::OFF_LATENCY, 32'h0201);
    wr(wtt_pkg::OFF_RECOVERY, 32'h0503);
    $display("registers done");
    for (int i = 0; i < 4; i++)
    begin
      wr(wtt_pkg::OFF_MODE, mode_t[i]);
      cap.delete();
      ctl.write_burst(2'h0, 2'h1, a12_t[i], 1'b0, 3, nb_t[i], 7, 8'h40);
      repeat (30) @(posedge clock);
      chk("beats", 32'(cap.size()), nb_t[i]);
      chk("first beat", 32'(cap[0]), 32'h40);
    end
    chk("no pulse", n_pulse, 32'h0);
    $display("burst length done");
    for (int i = 0; i < 2; i++)
    begin
      wr(wtt_pkg::OFF_MODE, i ? 32'h4 : 32'h0);
      n_rise = 32'h0;
      n_pulse = 32'h0;
      ctl.write_burst(2'h2, 2'h1, 1'b0, 1'b1, 3, 8, 9, 8'h00);
      repeat (10) @(posedge clock);
      chk("pulses", n_pulse, 32'h1);
      chk("pulse rise", pulse_rise, i ? 32'd13 : 32'd11);
      chk("pulse bank", 32'(pulse_bank), 32'h9);
    end
    $display("auto precharge done");
    wr(wtt_pkg::OFF_MODE, 32'h0);
    wr(wtt_pkg::OFF_RECOVERY, 32'h0506);
    ctl.write_burst(2'h1, 2'h2, 1'b1, 1'b0, 3, 8, 3, 8'h00);
    ctl.send(wtt_pkg::CMD_READ, 2'h2, 2'h0, 1'b1, 1'b0);
    ctl.send(wtt_pkg::CMD_PRECHARGE, 2'h1, 2'h2, 1'b0, 1'b0);
    repeat (4) ctl.slot();
    rd(wtt_pkg::OFF_STATUS, d);
    chk("flags a", 32'(d[4:3]), 32'h2);
    wr(wtt_pkg::OFF_STATUS, 32'h1c);
    ctl.write_burst(2'h1, 2'h2, 1'b1, 1'b0, 3, 8, 3, 8'h00);
    ctl.send(wtt_pkg::CMD_READ, 2'h1, 2'h0, 1'b1, 1'b0);
    repeat (4) ctl.slot();
    rd(wtt_pkg::OFF_STATUS, d);
    chk("flags b", 32'(d[4:3]), 32'h1);
    $display("turnaround done");
    @(posedge clock);
    wdata_ready <= 1'b0;
    cap.delete();
    repeat (5) ctl.write_burst(2'h3, 2'h3, 1'b1, 1'b0, 3, 8, 2, 8'h80);
    rd(wtt_pkg::OFF_STATUS, d);
    chk("overflow", 32'(d[5]), 32'h1);
    @(posedge clock);
    wdata_ready <= 1'b1;
    repeat (60) @(posedge clock);
    chk("drained", 32'(cap.size()), 32'd33);
    $display("buffer done");
    give_verdict();
  end
endmodule : test_wtt_write_turnaround
`default_nettype wire
